// ===== core/tcad_pkg.sv
package tcad_pkg;
   // Register map of the command decoder, byte addresses
   localparam int          REG_AW         = 4;
   localparam logic [3:0]  ADDR_CTRL      = 4'h0;
   localparam logic [3:0]  ADDR_STAT      = 4'h4;
   localparam logic [3:0]  ADDR_CMDA      = 4'h8;
   localparam logic [3:0]  ADDR_SUM       = 4'hc;
   localparam int          CTRL_EN_BIT    = 0;
   localparam logic        CTRL_EN_RST    = 1'b1;
   localparam int          STAT_DONE_BIT  = 0;
   localparam int          STAT_ERR_BIT   = 1;
   localparam int          STAT_OPEN_BIT  = 2;
   localparam int          STAT_FIRST_BIT = 3;

   // End alignment codes and the matching word masks
   localparam logic [1:0]  ALIGN_4        = 2'h0;
   localparam logic [1:0]  ALIGN_16       = 2'h1;
   localparam logic [1:0]  ALIGN_32       = 2'h2;
   localparam logic [1:0]  ALIGN_RSVD     = 2'h3;
   localparam logic [10:0] MASK_4         = 11'h000;
   localparam logic [10:0] MASK_16        = 11'h003;
   localparam logic [10:0] MASK_32        = 11'h007;

   // First transmit command word
   typedef struct packed {
      logic        ioc;
      logic [4:0]  rsvdHi;
      logic [1:0]  endAlign;
      logic [2:0]  rsvdMid;
      logic [4:0]  startOffset;
      logic [1:0]  rsvdLo;
      logic        firstSeg;
      logic        lastSeg;
      logic        rsvdBit;
      logic [10:0] bufSize;
   } tcad_cmd_a_t;

   // One payload DWORD handed to the transmit path
   typedef struct packed {
      logic [31:0] data;
      logic [3:0]  byteEn;
      logic        first;
      logic        last;
   } tcad_beat_t;

   typedef enum {S_CMDA, S_CMDB, S_BODY} tcad_state_t;
endpackage

// ===== core/tcad_tx_cmd_decoder.sv
`timescale 1ns/1ps
// Functional notes
// - Command bit 31 raises the loaded flag when the whole buffer has arrived.
// - Padding DWORDs after the payload are dropped and never forwarded.
// - Alignment code 00 is 4 bytes, 01 is 16, 10 is 32, 11 reserved.
// - Bits 20:16 give the byte offset of the first byte sent; earlier bytes ignored.
// - Offset low bits pick the first byte lane; upper bits skip up to seven DWORDs.
// - Bit 13 marks the buffer as the first segment of a packet.
// - Bit 12 marks the buffer as the last segment, closing the packet.
// - Buffer sizes are summed per packet; mismatch with packet length sets error.
module tcad_tx_cmd_decoder
   import tcad_pkg::*;
(
   // Clock and reset
   input  wire logic              mclk,
   input  wire logic              resetn,
   // Transmit data FIFO write side
   input  wire logic              hostWrite,
   input  wire logic [31:0]       hostData,
   // Register port
   input  wire logic [REG_AW-1:0] regAddr,
   input  wire logic [31:0]       regWrData,
   input  wire logic              regWrite,
   input  wire logic              regRead,
   output logic      [31:0]       regRdData,
   // Payload towards the transmitter
   output logic                   outValid,
   output tcad_beat_t             outBeat,
   // Flags
   output logic                   txBufferLoadedFlag,
   output logic                   transmitErrorFlag,
   output logic                   firstSegmentMarker
);

   tcad_state_t state_reg;
   tcad_cmd_a_t cmd_reg;
   tcad_cmd_a_t cmdIn;
   logic        enable_reg;
   logic        doneSticky_reg;
   logic        pktOpen_reg;
   logic [10:0] pktLen_reg;
   logic [11:0] sum_reg;
   logic [10:0] wordIdx_reg;
   logic [10:0] skipWords_reg;
   logic [10:0] dataEnd_reg;
   logic [10:0] bufWords_reg;
   logic [1:0]  endLane_reg;

   logic        active;
   logic [1:0]  startLane;
   logic [10:0] dataWords;
   logic [10:0] rawWords;
   logic [10:0] alignMask;
   logic [10:0] bufWords_next;
   logic [11:0] sum_next;
   logic        bufDone;
   logic        inBody;
   logic        isData;
   logic        isFirstData;
   logic        isLastData;
   logic        errSet;
   logic        errClr;
   logic        doneClr;

   assign cmdIn     = tcad_cmd_a_t'(hostData);
   assign active    = hostWrite && enable_reg;
   assign startLane = cmd_reg.startOffset[1:0];

   // Buffer geometry, valid while the second command word arrives
   always_comb begin
      if (cmd_reg.bufSize == 11'h000) begin
         dataWords = 11'h000;
      end else begin
         dataWords = 11'((12'(cmd_reg.bufSize) + 12'(startLane) + 12'h003) >> 2);
      end
      rawWords = 11'(cmd_reg.startOffset[4:2]) + dataWords;
      case (cmd_reg.endAlign)
         ALIGN_4:  alignMask = MASK_4;
         ALIGN_16: alignMask = MASK_16;
         ALIGN_32: alignMask = MASK_32;
         default:  alignMask = MASK_4;
      endcase
      bufWords_next = (rawWords + alignMask) & ~alignMask;
   end

   assign inBody      = active && (state_reg == S_BODY);
   assign isData      = (wordIdx_reg >= skipWords_reg) && (wordIdx_reg < dataEnd_reg);
   assign isFirstData = (wordIdx_reg == skipWords_reg);
   assign isLastData  = (wordIdx_reg == dataEnd_reg - 11'h001);
   assign bufDone     = (active && (state_reg == S_CMDB) && (bufWords_next == 11'h000))
                        || (inBody && (wordIdx_reg == bufWords_reg - 11'h001));
   assign sum_next    = (cmd_reg.firstSeg ? 12'h000 : sum_reg) + 12'(cmd_reg.bufSize);

   // Command parser
   always_ff @(posedge mclk) begin
      if (!resetn || !enable_reg) begin
         state_reg <= S_CMDA;
      end else if (hostWrite) begin
         case (state_reg)
            S_CMDA: state_reg <= S_CMDB;
            S_CMDB: state_reg <= (bufWords_next == 11'h000) ? S_CMDA : S_BODY;
            S_BODY: state_reg <= bufDone ? S_CMDA : S_BODY;
            default: state_reg <= S_CMDA;
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (!resetn) begin
         cmd_reg <= '0;
      end else if (active && state_reg == S_CMDA) begin
         cmd_reg <= cmdIn;
      end
   end

   // Word counter and per-buffer geometry
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         wordIdx_reg   <= 11'h000;
         skipWords_reg <= 11'h000;
         dataEnd_reg   <= 11'h000;
         bufWords_reg  <= 11'h000;
         endLane_reg   <= 2'h0;
      end else if (active && state_reg == S_CMDB) begin
         wordIdx_reg   <= 11'h000;
         skipWords_reg <= 11'(cmd_reg.startOffset[4:2]);
         dataEnd_reg   <= rawWords;
         bufWords_reg  <= bufWords_next;
         endLane_reg   <= 2'(startLane + cmd_reg.bufSize[1:0] - 2'h1);
      end else if (inBody) begin
         wordIdx_reg <= wordIdx_reg + 11'h001;
      end
   end

   // Payload beats; skipped and pad words produce none
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         outValid <= 1'b0;
         outBeat  <= '0;
      end else begin
         outValid <= inBody && isData;
         if (inBody && isData) begin
            outBeat.data   <= hostData;
            outBeat.byteEn <= (isFirstData ? (4'hf << startLane) : 4'hf)
                              & (isLastData ? (4'hf >> (2'h3 - endLane_reg)) : 4'hf);
            outBeat.first  <= isFirstData && cmd_reg.firstSeg;
            outBeat.last   <= isLastData && cmd_reg.lastSeg;
         end
      end
   end

   // Packet tracking across buffers
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         pktOpen_reg <= 1'b0;
         pktLen_reg  <= 11'h000;
         sum_reg     <= 12'h000;
      end else begin
         if (active && state_reg == S_CMDB && cmd_reg.firstSeg) begin
            pktLen_reg <= hostData[10:0];
         end
         if (bufDone) begin
            sum_reg     <= sum_next;
            pktOpen_reg <= !cmd_reg.lastSeg;
         end else if (active && state_reg == S_CMDB && cmd_reg.firstSeg) begin
            pktOpen_reg <= 1'b1;
         end
      end
   end

   // Error sources
   always_comb begin
      errSet = 1'b0;
      if (active && state_reg == S_CMDA) begin
         errSet = (cmdIn.endAlign == ALIGN_RSVD)
                  || (cmdIn.rsvdHi != 5'h00) || (cmdIn.rsvdMid != 3'h0);
      end
      if (active && state_reg == S_CMDB) begin
         if (cmd_reg.firstSeg) begin
            errSet = pktOpen_reg;
         end else begin
            errSet = !pktOpen_reg || (hostData[10:0] != pktLen_reg);
         end
      end
      // Packet length sits on the bus only while command B is taken
      if (bufDone && cmd_reg.lastSeg && state_reg == S_CMDB) begin
         errSet = errSet || (sum_next != 12'(hostData[10:0]));
      end
      if (bufDone && cmd_reg.lastSeg && state_reg == S_BODY) begin
         errSet = errSet || (sum_next != 12'(pktLen_reg));
      end
   end

   assign errClr  = regWrite && regAddr == ADDR_STAT && regWrData[STAT_ERR_BIT];
   assign doneClr = regWrite && regAddr == ADDR_STAT && regWrData[STAT_DONE_BIT];

   // Sticky flags, set beats clear
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         transmitErrorFlag <= 1'b0;
         doneSticky_reg    <= 1'b0;
      end else begin
         transmitErrorFlag <= errSet || (transmitErrorFlag && !errClr);
         doneSticky_reg    <= (bufDone && cmd_reg.ioc) || (doneSticky_reg && !doneClr);
      end
   end

   always_ff @(posedge mclk) begin
      if (!resetn) begin
         txBufferLoadedFlag <= 1'b0;
         firstSegmentMarker <= 1'b0;
      end else begin
         txBufferLoadedFlag <= bufDone && cmd_reg.ioc;
         firstSegmentMarker <= (state_reg != S_CMDA) && cmd_reg.firstSeg;
      end
   end

   // Register port
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         enable_reg <= CTRL_EN_RST;
      end else if (regWrite && regAddr == ADDR_CTRL) begin
         enable_reg <= regWrData[CTRL_EN_BIT];
      end
   end

   always_ff @(posedge mclk) begin
      if (!resetn) begin
         regRdData <= 32'h0000_0000;
      end else begin
         regRdData <= 32'h0000_0000;
         if (regRead) begin
            case (regAddr)
               ADDR_CTRL: regRdData[CTRL_EN_BIT] <= enable_reg;
               ADDR_STAT: begin
                  regRdData[STAT_DONE_BIT]  <= doneSticky_reg;
                  regRdData[STAT_ERR_BIT]   <= transmitErrorFlag;
                  regRdData[STAT_OPEN_BIT]  <= pktOpen_reg;
                  regRdData[STAT_FIRST_BIT] <= firstSegmentMarker;
               end
               ADDR_CMDA: regRdData <= 32'(cmd_reg);
               ADDR_SUM:  regRdData <= 32'(sum_reg);
               default:   regRdData <= 32'h0000_0000;
            endcase
         end
      end
   end

   // Checks
   loaded_flag_a: assert property (@(posedge mclk) disable iff (!resetn)
      bufDone && cmd_reg.ioc |=> txBufferLoadedFlag && doneSticky_reg)
      else $error("loaded flag missing after buffer end");

   pad_drop_a: assert property (@(posedge mclk) disable iff (!resetn)
      inBody && (wordIdx_reg >= dataEnd_reg) |=> !outValid)
      else $error("pad word forwarded");

   align_code_a: assert property (@(posedge mclk) disable iff (!resetn)
      active && state_reg == S_CMDA && cmdIn.endAlign == ALIGN_RSVD |=> transmitErrorFlag)
      else $error("reserved alignment not flagged");

   first_lane_a: assert property (@(posedge mclk) disable iff (!resetn)
      inBody && isData && isFirstData && !isLastData
      |=> outValid && outBeat.byteEn == (4'hf << $past(startLane)))
      else $error("first byte lane wrong");

   skip_words_a: assert property (@(posedge mclk) disable iff (!resetn)
      inBody && wordIdx_reg < 11'(cmd_reg.startOffset[4:2]) |=> !outValid)
      else $error("skipped DWORD forwarded");

   first_seg_a: assert property (@(posedge mclk) disable iff (!resetn)
      outValid && outBeat.first |-> $past(cmd_reg.firstSeg) && $past(isFirstData))
      else $error("first marker without segment bit");

   last_seg_a: assert property (@(posedge mclk) disable iff (!resetn)
      bufDone && cmd_reg.lastSeg |=> !pktOpen_reg)
      else $error("packet not closed by last segment");

   length_check_a: assert property (@(posedge mclk) disable iff (!resetn)
      bufDone && cmd_reg.lastSeg && state_reg == S_BODY && sum_next != 12'(pktLen_reg)
      |=> transmitErrorFlag)
      else $error("length mismatch not flagged");

   pad_count_a: assert property (@(posedge mclk) disable iff (!resetn)
      active && state_reg == S_CMDB |=> (bufWords_reg & $past(alignMask)) == 11'h000
      && bufWords_reg >= dataEnd_reg)
      else $error("buffer word count not aligned");

   loaded_source_a: assert property (@(posedge mclk) disable iff (!resetn)
      txBufferLoadedFlag |-> $past(bufDone) && $past(cmd_reg.ioc))
      else $error("loaded flag without finished buffer");

   lane_nonzero_a: assert property (@(posedge mclk) disable iff (!resetn)
      outValid |-> outBeat.byteEn != 4'h0)
      else $error("beat with no valid byte");

   last_beat_a: assert property (@(posedge mclk) disable iff (!resetn)
      outValid && outBeat.last |-> $past(cmd_reg.lastSeg) && $past(isLastData))
      else $error("last marker without segment bit");

endmodule // tcad_tx_cmd_decoder

// ===== tb/tcad_host_model.sv
`timescale 1ns/1ps
module tcad_host_model
   import tcad_pkg::*;
(
   // Clock
   input  wire logic        mclk,
   // Transmit data FIFO write side
   output logic             hostWrite,
   output logic [31:0]      hostData
);
   tcad_beat_t expQ[$];
   int         doneExp = 0;

   initial begin
      hostWrite = 1'b0;
      hostData  = 32'h0;
   end

   task automatic put(input logic [31:0] w);
      @(posedge mclk);
      hostWrite <= 1'b1;
      hostData  <= w;
   endtask

   // Drops the write strobe; data lines inverted so stale data is never mistaken
   task automatic idle();
      @(posedge mclk);
      hostWrite <= 1'b0;
      hostData  <= ~hostData;
   endtask

   // One buffer: command A, command B, skip, data and pad words
   task automatic send_buf(input tcad_cmd_a_t c, input logic [10:0] len, input bit chk);
      int         skip, nData, nAll, al, d;
      logic [1:0] lane;
      tcad_beat_t b;
      logic [31:0] w;
      skip  = int'(c.startOffset[4:2]);
      nData = (c.bufSize == 0) ? 0 : (int'(c.startOffset[1:0]) + int'(c.bufSize) + 3) / 4;
      al    = (c.endAlign == ALIGN_32) ? 8 : (c.endAlign == ALIGN_16) ? 4 : 1;
      nAll  = ((skip + nData + al - 1) / al) * al;
      lane  = 2'(11'(c.startOffset[1:0]) + c.bufSize - 11'h1);
      put(c);
      put({16'($urandom), 5'h0, len});
      for (int k = 0; k < nAll; k++) begin
         w = $urandom;
         put(w);
         d = k - skip;
         if (chk && d >= 0 && d < nData) begin
            b.data   = w;
            b.byteEn = 4'hf;
            if (d == 0) b.byteEn = b.byteEn & (4'hf << c.startOffset[1:0]);
            if (d == nData - 1) b.byteEn = b.byteEn & 4'((5'h2 << lane) - 5'h1);
            b.first  = (d == 0) && c.firstSeg;
            b.last   = (d == nData - 1) && c.lastSeg;
            expQ.push_back(b);
         end
      end
      if (chk && c.ioc) doneExp++;
   endtask
endmodule // tcad_host_model

// ===== tb/test_tcad_tx_cmd_decoder.sv
`timescale 1ns/1ps
module test_tcad_tx_cmd_decoder
   import tcad_pkg::*;
;
   logic              mclk, resetn, hostWrite, regWrite, regRead, outValid;
   logic              txBufferLoadedFlag, transmitErrorFlag, firstSegmentMarker;
   logic [31:0]       hostData, regWrData, regRdData;
   logic [REG_AW-1:0] regAddr;
   tcad_beat_t        outBeat;
   int                err_count = 0;
   int                comparisons = 0;
   int                doneSeen = 0;
   tcad_beat_t        expBeat;

   tcad_host_model i_host (.mclk(mclk), .hostWrite(hostWrite), .hostData(hostData));
   tcad_tx_cmd_decoder i_dut (
      .mclk(mclk), .resetn(resetn), .hostWrite(hostWrite), .hostData(hostData),
      .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
      .regRdData(regRdData), .outValid(outValid), .outBeat(outBeat),
      .txBufferLoadedFlag(txBufferLoadedFlag), .transmitErrorFlag(transmitErrorFlag),
      .firstSegmentMarker(firstSegmentMarker));

   always #20 mclk = ~mclk;

   task automatic check(input string what, input logic [37:0] exp, input logic [37:0] got);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic finish_test();
      $display("Comparisons %0d errors %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge mclk);
      regWrite  <= 1'b1;
      regAddr   <= a;
      regWrData <= d;
      @(posedge mclk);
      regWrite  <= 1'b0;
   endtask

   task automatic reg_rd(input logic [3:0] a, input logic [31:0] exp, input string what);
      @(posedge mclk);
      regRead <= 1'b1;
      regAddr <= a;
      @(posedge mclk);
      regRead <= 1'b0;
      @(negedge mclk);
      check(what, 38'(exp), 38'(regRdData));
   endtask

   // Error flag level after a bounded settling wait
   task automatic err_is(input logic exp);
      i_host.idle();
      @(negedge mclk);
      for (int k = 0; k < 12 && transmitErrorFlag !== exp; k++) @(negedge mclk);
      check("error flag", 38'(exp), 38'(transmitErrorFlag));
   endtask

   function automatic tcad_cmd_a_t mk(input logic ioc, input logic [1:0] al,
         input logic [4:0] off, input logic fs, input logic ls, input logic [10:0] sz);
      tcad_cmd_a_t c;
      c = '0;
      c.ioc = ioc;
      c.endAlign = al;
      c.startOffset = off;
      c.firstSeg = fs;
      c.lastSeg = ls;
      c.bufSize = sz;
      return c;
   endfunction

   // Scoreboard: oldest expected beat against each forwarded beat
   always @(negedge mclk) begin
      if (outValid === 1'b1) begin
         if (i_host.expQ.size() == 0) check("spare beat", 38'h0, 38'h1);
         else begin
            expBeat = i_host.expQ.pop_front();
            check("beat", expBeat, outBeat);
            if (expBeat.first) check("first marker", 38'h1, 38'(firstSegmentMarker));
         end
      end
      if (txBufferLoadedFlag === 1'b1) doneSeen++;
   end

   initial begin
      repeat (60000) @(posedge mclk);
      $display("Error timeout");
      err_count++;
      finish_test();
   end

   initial begin
      tcad_cmd_a_t c;
      mclk = 1'b0;
      resetn = 1'b0;
      regAddr = '0;
      regWrData = '0;
      regWrite = 1'b0;
      regRead = 1'b0;
      void'($urandom(89));
      repeat (4) @(posedge mclk);
      resetn <= 1'b1;
      reg_rd(ADDR_CTRL, 32'h1, "ctrl reset");
      reg_rd(ADDR_STAT, 32'h0, "stat reset");
      reg_rd(4'h2, 32'h0, "unmapped");
      for (int k = 0; k < 24; k++) begin
         c = mk(k[0], 2'(k % 3), 5'($urandom), 1'b1, 1'b1, 11'($urandom_range(40)));
         i_host.send_buf(c, c.bufSize, 1'b1);
      end
      i_host.send_buf(mk(1'b1, ALIGN_32, 5'h1f, 1'b1, 1'b1, 11'h1), 11'h1, 1'b1);
      i_host.send_buf(mk(1'b0, ALIGN_16, 5'h3, 1'b1, 1'b1, 11'h7ff), 11'h7ff, 1'b1);
      i_host.send_buf(mk(1'b0, ALIGN_4, 5'h1, 1'b1, 1'b0, 11'h5), 11'h12, 1'b1);
      i_host.send_buf(mk(1'b0, ALIGN_16, 5'h6, 1'b0, 1'b0, 11'h6), 11'h12, 1'b1);
      c = mk(1'b1, ALIGN_32, 5'h2, 1'b0, 1'b1, 11'h7);
      i_host.send_buf(c, 11'h12, 1'b1);
      err_is(1'b0);
      reg_rd(ADDR_CMDA, 32'(c), "last command");
      for (int k = 0; k < 3; k++) begin
         c = mk(1'b0, k == 1 ? ALIGN_RSVD : ALIGN_16, 5'h5, 1'b1, 1'b1, 11'h9);
         if (k == 0) c.rsvdHi = 5'h1;
         i_host.send_buf(c, k == 2 ? 11'ha : 11'h9, 1'b1);
         err_is(1'b1);
         reg_wr(ADDR_STAT, 32'h2);
         err_is(1'b0);
      end
      reg_wr(ADDR_CTRL, 32'h0);
      i_host.send_buf(mk(1'b1, ALIGN_4, 5'h0, 1'b1, 1'b1, 11'h8), 11'h8, 1'b0);
      i_host.idle();
      reg_wr(ADDR_CTRL, 32'h1);
      reg_wr(ADDR_STAT, 32'h3);
      reg_rd(ADDR_STAT, 32'h0, "stat cleared");
      i_host.send_buf(mk(1'b1, ALIGN_4, 5'h4, 1'b1, 1'b1, 11'h3), 11'h3, 1'b1);
      err_is(1'b0);
      reg_rd(ADDR_STAT, 32'h1, "stat loaded");
      for (int k = 0; k < 20 && i_host.expQ.size() != 0; k++) @(posedge mclk);
      check("beats left", 38'h0, 38'(i_host.expQ.size()));
      check("loaded pulses", 38'(i_host.doneExp), 38'(doneSeen));
      finish_test();
   end
endmodule // test_tcad_tx_cmd_decoder
